// *** design/rss_ctrl.sv ***
// ramp spread-spectrum control: register file and ramp generator hookup
// Operation
// - register 0x6b bit 4 puts the spread controller into manual mode, default 0
// - manual mode with bit 5 set clocks the controller at half rate
// - bit 0 enables triangle, bit 1 random; 4-bit triangle control field, default 0
// - manual ramp rate is 61440000 over the 8-bit divisor, default 0xa0
// - manual triangle fall step from bits 7-4 of step register, default 1
// - manual triangle rise step from bits 3-0 of step register, default 1
// - manual ramp amplitude from bits 6-5 of 0x6f, default 01
// - manual triangle period bound from bits 4-0 of 0x6f, default 00100
`timescale 1ns/1ps
`default_nettype none

module rss_ctrl #(
    parameter int OFS_W = 8
) (
    // clock and reset
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    // register port
    input  wire logic [7:0]       addr_i,
    input  wire logic [7:0]       wdata_i,
    input  wire logic             wr_i,
    input  wire logic             rd_i,
    output logic      [7:0]       rdata_o,
    // ramp control outputs
    output logic                  ramp_tick_o,
    output logic [OFS_W-1:0]      spread_ofs_o,
    output logic [7:0]            ramp_divisor_o,
    output logic [1:0]            ramp_amp_o,
    output logic                  manual_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // register file

    rss_pkg::rss_bus_t bus;
    assign bus = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

    logic [7:0] mode_reg;
    logic [7:0] prof_reg;
    logic [7:0] div_reg;
    logic [7:0] step_reg;
    logic [7:0] ampb_reg;
    logic [7:0] rdata_reg;
    logic       half_reg;
    logic       tri_dir;

    wire wr_mode = bus.wr && bus.addr == rss_pkg::ADDR_MODE_CTRL;
    wire wr_prof = bus.wr && bus.addr == rss_pkg::ADDR_PROFILE_SEL;
    wire wr_div  = bus.wr && bus.addr == rss_pkg::ADDR_DIVISOR;
    wire wr_step = bus.wr && bus.addr == rss_pkg::ADDR_STEPS;
    wire wr_ampb = bus.wr && bus.addr == rss_pkg::ADDR_AMP_BOUND;

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            mode_reg <= rss_pkg::RST_MODE_CTRL;
            prof_reg <= rss_pkg::RST_PROFILE_SEL;
            div_reg  <= rss_pkg::RST_DIVISOR;
            step_reg <= rss_pkg::RST_STEPS;
            ampb_reg <= rss_pkg::RST_AMP_BOUND;
        end
        else
        begin
            if (wr_mode) mode_reg <= bus.wdata;
            if (wr_prof) prof_reg <= bus.wdata;
            if (wr_div)  div_reg  <= bus.wdata;
            if (wr_step) step_reg <= bus.wdata;
            if (wr_ampb) ampb_reg <= bus.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // configuration decode

    rss_pkg::rss_cfg_t cfg;
    assign cfg.manual    = mode_reg[rss_pkg::BIT_MANUAL];
    assign cfg.pre_div   = mode_reg[rss_pkg::BIT_PRE_DIV];
    assign cfg.tri_en    = mode_reg[rss_pkg::BIT_TRI_EN];
    assign cfg.rdm_en    = mode_reg[rss_pkg::BIT_RDM_EN];
    assign cfg.tri_ctrl  = prof_reg[rss_pkg::TRI_CTRL_LSB +: 4];
    assign cfg.dither    = prof_reg[rss_pkg::DITHER_LSB +: 3];
    assign cfg.divisor   = div_reg;
    assign cfg.fall_step = step_reg[rss_pkg::FALL_LSB +: 4];
    assign cfg.rise_step = step_reg[rss_pkg::RISE_LSB +: 4];
    assign cfg.amp       = ampb_reg[rss_pkg::AMP_LSB +: 2];
    assign cfg.bound     = ampb_reg[rss_pkg::BOUND_LSB +: 5];

    ////////////////////////////////////////////////////////////////////////////////
    // source clock enable: full rate, or half rate in manual pre-divide

    wire use_half = cfg.manual && cfg.pre_div;
    wire src_en   = use_half ? half_reg : 1'b1;

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            half_reg <= 1'b0;
        else
            half_reg <= use_half ? ~half_reg : 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read path

    wire [7:0] status_val = {5'h00, spread_ofs_o != '0, cfg.manual, tri_dir};
    wire [7:0] rd_mux =
        (bus.addr == rss_pkg::ADDR_MODE_CTRL)   ? mode_reg :
        (bus.addr == rss_pkg::ADDR_PROFILE_SEL) ? prof_reg :
        (bus.addr == rss_pkg::ADDR_DIVISOR)     ? div_reg  :
        (bus.addr == rss_pkg::ADDR_STEPS)       ? step_reg :
        (bus.addr == rss_pkg::ADDR_AMP_BOUND)   ? ampb_reg :
        (bus.addr == rss_pkg::ADDR_STATUS)      ? status_val : 8'h00;

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= bus.rd ? rd_mux : 8'h00;
    end

    assign rdata_o = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // ramp generator

    rss_ramp_gen #(
        .OFS_W (OFS_W)
    ) u_gen (
        .mclk_i       (mclk_i),
        .rst_i        (rst_i),
        .cfg_i        (cfg),
        .src_en_i     (src_en),
        .ramp_tick_o  (ramp_tick_o),
        .spread_ofs_o (spread_ofs_o),
        .tri_dir_o    (tri_dir)
    );

    // manual divisor and amplitude only drive the ramp in manual mode
    assign ramp_divisor_o = cfg.manual ? cfg.divisor : rss_pkg::RST_DIVISOR;
    assign ramp_amp_o     = cfg.manual ? cfg.amp : 2'b01;
    assign manual_o       = cfg.manual;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    a_manual_follow: assert property (@(posedge mclk_i) disable iff (rst_i)
        wr_mode |=> manual_o == $past(wdata_i[4]))
        else $error("manual flag does not follow write");

    a_half_rate: assert property (@(posedge mclk_i) disable iff (rst_i)
        use_half && src_en |=> !src_en || !use_half)
        else $error("half rate enable repeated");

    a_off_no_spread: assert property (@(posedge mclk_i) disable iff (rst_i)
        !cfg.tri_en && !cfg.rdm_en |=> spread_ofs_o == '0)
        else $error("offset without spreading enabled");

    a_divisor_out: assert property (@(posedge mclk_i) disable iff (rst_i)
        !manual_o |-> ramp_divisor_o == 8'ha0)
        else $error("divisor not default outside manual");

    a_step_store: assert property (@(posedge mclk_i) disable iff (rst_i)
        wr_step |=> step_reg == $past(wdata_i))
        else $error("step register not written");

    a_amp_out: assert property (@(posedge mclk_i) disable iff (rst_i)
        manual_o |-> ramp_amp_o == ampb_reg[6:5])
        else $error("amplitude not from register");

    a_bound_store: assert property (@(posedge mclk_i) disable iff (rst_i)
        wr_ampb |=> cfg.bound == $past(wdata_i[4:0]))
        else $error("bound not stored");

    a_read_back: assert property (@(posedge mclk_i) disable iff (rst_i)
        rd_i && addr_i == 8'h6b |=> rdata_o == mode_reg)
        else $error("mode readback wrong");

    a_idle_read: assert property (@(posedge mclk_i) disable iff (rst_i)
        !rd_i |=> rdata_o == 8'h00)
        else $error("read data outside read cycle");

    c_triangle: cover property (@(posedge mclk_i) cfg.tri_en && tri_dir);
    c_random:   cover property (@(posedge mclk_i) cfg.rdm_en && cfg.dither != 3'h0 && ramp_tick_o);
    c_half:     cover property (@(posedge mclk_i) use_half && ramp_tick_o);

endmodule

`default_nettype wire

// *** design/rss_pkg.sv ***
// package: register map, field layout and timing constants for the ramp spread controller
package rss_pkg;

    // register addresses
    localparam logic [7:0] ADDR_MODE_CTRL   = 8'h6b;
    localparam logic [7:0] ADDR_PROFILE_SEL = 8'h6c;
    localparam logic [7:0] ADDR_DIVISOR     = 8'h6d;
    localparam logic [7:0] ADDR_STEPS       = 8'h6e;
    localparam logic [7:0] ADDR_AMP_BOUND   = 8'h6f;
    localparam logic [7:0] ADDR_STATUS      = 8'h60;

    // reset values
    localparam logic [7:0] RST_MODE_CTRL   = 8'h00;
    localparam logic [7:0] RST_PROFILE_SEL = 8'h00;
    localparam logic [7:0] RST_DIVISOR     = 8'ha0;
    localparam logic [7:0] RST_STEPS       = 8'h11;
    localparam logic [7:0] RST_AMP_BOUND   = 8'h24;

    // field positions
    localparam int BIT_TRI_EN     = 0;
    localparam int BIT_RDM_EN     = 1;
    localparam int BIT_MANUAL     = 4;
    localparam int BIT_PRE_DIV    = 5;
    localparam int TRI_CTRL_LSB   = 0;
    localparam int DITHER_LSB     = 4;
    localparam int RISE_LSB       = 0;
    localparam int FALL_LSB       = 4;
    localparam int BOUND_LSB      = 0;
    localparam int AMP_LSB        = 5;

    // nominal ramp rate numerator in hz
    localparam int RAMP_NUM_HZ = 61440000;

    // lfsr seed for random spreading
    localparam logic [15:0] LFSR_SEED = 16'hace1;

    // decoded configuration carried to the ramp generator
    typedef struct packed {
        logic       manual;
        logic       pre_div;
        logic       tri_en;
        logic       rdm_en;
        logic [3:0] tri_ctrl;
        logic [2:0] dither;
        logic [7:0] divisor;
        logic [3:0] rise_step;
        logic [3:0] fall_step;
        logic [4:0] bound;
        logic [1:0] amp;
    } rss_cfg_t;

    // register bus request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rss_bus_t;

endpackage

// *** design/rss_ramp_gen.sv ***
// ramp tick generator with triangle and random period spreading
`timescale 1ns/1ps
`default_nettype none

module rss_ramp_gen #(
    parameter int OFS_W = 8
) (
    // clock and reset
    input  wire logic            mclk_i,
    input  wire logic            rst_i,
    // configuration and source enable
    input  wire rss_pkg::rss_cfg_t cfg_i,
    input  wire logic            src_en_i,
    // ramp outputs
    output logic                 ramp_tick_o,
    output logic [OFS_W-1:0]     spread_ofs_o,
    output logic                 tri_dir_o
);

    // the period adder reads eight offset bits
    if (OFS_W < 8)
    begin : g_ofs_w_check
        $error("OFS_W too small");
    end

    logic [8:0]       cnt_reg;
    logic [OFS_W-1:0] ofs_reg;
    logic             dir_reg;
    logic [15:0]      lfsr_reg;
    logic [3:0]       tri_div_reg;
    logic             tick_reg;

    wire [7:0]       div_eff   = cfg_i.manual ? cfg_i.divisor : rss_pkg::RST_DIVISOR;
    wire [8:0]       period    = {1'b0, div_eff} + {1'b0, ofs_reg[7:0]};
    wire             cnt_done  = src_en_i && (cnt_reg + 9'h001 >= period);
    wire [OFS_W-1:0] bound_ext = OFS_W'(cfg_i.manual ? cfg_i.bound : 5'(cfg_i.tri_ctrl));
    wire [3:0]       up_step   = cfg_i.manual ? cfg_i.rise_step : 4'h1;
    wire [3:0]       dn_step   = cfg_i.manual ? cfg_i.fall_step : 4'h1;
    wire             tri_step  = cfg_i.tri_en && cnt_done &&
                                 (cfg_i.manual || tri_div_reg == cfg_i.tri_ctrl);
    wire [OFS_W-1:0] ofs_up    = ofs_reg + OFS_W'(up_step);
    wire [OFS_W-1:0] ofs_dn    = (ofs_reg > OFS_W'(dn_step)) ? ofs_reg - OFS_W'(dn_step) : '0;
    wire             lfsr_fb   = lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10];
    wire [OFS_W-1:0] rdm_ofs   = OFS_W'(lfsr_reg[4:0] & bound_ext[4:0])
                                 + OFS_W'(lfsr_reg[12:10] & cfg_i.dither);
    wire [OFS_W-1:0] ofs_next  = cfg_i.tri_en ? (tri_step ? (dir_reg ? ofs_dn : ofs_up) : ofs_reg)
                               : cfg_i.rdm_en ? (cnt_done ? rdm_ofs : ofs_reg)
                               : '0;
    wire             dir_next  = !cfg_i.tri_en ? 1'b0
                               : !tri_step ? dir_reg
                               : (!dir_reg && ofs_up >= bound_ext) ? 1'b1
                               : (dir_reg && ofs_dn == '0) ? 1'b0 : dir_reg;

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            cnt_reg     <= 9'h000;
            ofs_reg     <= '0;
            dir_reg     <= 1'b0;
            lfsr_reg    <= rss_pkg::LFSR_SEED;
            tri_div_reg <= 4'h0;
            tick_reg    <= 1'b0;
        end
        else
        begin
            tick_reg <= cnt_done;
            if (src_en_i)
                cnt_reg <= cnt_done ? 9'h000 : cnt_reg + 9'h001;
            if (cnt_done)
            begin
                lfsr_reg    <= {lfsr_reg[14:0], lfsr_fb};
                tri_div_reg <= (tri_div_reg == cfg_i.tri_ctrl) ? 4'h0 : tri_div_reg + 4'h1;
            end
            ofs_reg <= ofs_next;
            dir_reg <= dir_next;
        end
    end

    assign ramp_tick_o  = tick_reg;
    assign spread_ofs_o = ofs_reg;
    assign tri_dir_o    = dir_reg;

endmodule

`default_nettype wire

// *** verif/tb_rss_ctrl.sv ***
// self-checking testbench for the ramp spread-spectrum controller
`timescale 1ns/1ps
`default_nettype none

module tb_rss_ctrl;

    ////////////////////////////////////////////////////////////////////////
    logic       mclk_i;
    logic       rst_i;
    logic [7:0] addr_i;
    logic [7:0] wdata_i;
    logic       wr_i;
    logic       rd_i;
    logic [7:0] rdata_o;
    logic       ramp_tick_o;
    logic [7:0] spread_ofs_o;
    logic [7:0] ramp_divisor_o;
    logic [1:0] ramp_amp_o;
    logic       manual_o;
    int         num_errors = 0;
    int         checked = 0;
    logic [7:0] reg_addr [5];
    logic [7:0] shadow [5];
    logic [7:0] rd_val;
    logic [7:0] mx;
    int         per;
    int         idx;
    int         seed_val;

    rss_ctrl #(.OFS_W(8)) u_dut (
        .mclk_i         (mclk_i),
        .rst_i          (rst_i),
        .addr_i         (addr_i),
        .wdata_i        (wdata_i),
        .wr_i           (wr_i),
        .rd_i           (rd_i),
        .rdata_o        (rdata_o),
        .ramp_tick_o    (ramp_tick_o),
        .spread_ofs_o   (spread_ofs_o),
        .ramp_divisor_o (ramp_divisor_o),
        .ramp_amp_o     (ramp_amp_o),
        .manual_o       (manual_o)
    );

    initial mclk_i = 1'b0;
    always #2.5 mclk_i = ~mclk_i;

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
        checked++;
        if ((^got === 1'bx) || got < lo || got > hi)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    // cycles between two ticks, taken after one full period has settled
    task automatic period(output int p);
        int n;
        n = 0;
        p = 0;
        repeat (2)
        begin
            @(posedge mclk_i);
            #1;
            while (ramp_tick_o !== 1'b1 && n < 3000)
            begin
                @(posedge mclk_i);
                #1;
                n++;
            end
        end
        @(posedge mclk_i);
        #1;
        p = 1;
        while (ramp_tick_o !== 1'b1 && p < 3000)
        begin
            @(posedge mclk_i);
            #1;
            p++;
        end
    endtask

    // largest spread offset seen over a stretch of cycles
    task automatic obs(output logic [7:0] m);
        m = 8'h00;
        repeat (600)
        begin
            @(posedge mclk_i);
            #1;
            if (spread_ofs_o > m)
                m = spread_ofs_o;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        num_errors++;
        end_sim();
    end

    initial
    begin
        rst_i    = 1'b1;
        addr_i   = 8'h00;
        wdata_i  = 8'h00;
        wr_i     = 1'b0;
        rd_i     = 1'b0;
        reg_addr = '{rss_pkg::ADDR_MODE_CTRL, rss_pkg::ADDR_PROFILE_SEL, rss_pkg::ADDR_DIVISOR,
                     rss_pkg::ADDR_STEPS, rss_pkg::ADDR_AMP_BOUND};
        shadow   = '{8'h00, 8'h00, 8'ha0, 8'h11, 8'h24};
        seed_val = $urandom(32'hdbe0b148);
        repeat (10) @(posedge mclk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            rd(reg_addr[i], rd_val);
            chk(rd_val, shadow[i]);
        end
        chk(ramp_divisor_o, 8'ha0);
        chk({6'h00, ramp_amp_o}, 8'h01);
        chk({7'h00, manual_o}, 8'h00);
        $display("test reset_values done");
        for (int i = 0; i < 24; i++)
        begin
            idx = $urandom_range(4);
            shadow[idx] = 8'($urandom());
            wr(reg_addr[idx], shadow[idx]);
            rd(reg_addr[idx], rd_val);
            chk(rd_val, shadow[idx]);
        end
        wr(8'h5a, 8'hff);
        rd(8'h5a, rd_val);
        chk(rd_val, 8'h00);
        for (int i = 0; i < 5; i++)
        begin
            rd(reg_addr[i], rd_val);
            chk(rd_val, shadow[i]);
        end
        $display("test random_access done");
        wr(rss_pkg::ADDR_DIVISOR, 8'h10);
        wr(rss_pkg::ADDR_AMP_BOUND, 8'h45);
        wr(rss_pkg::ADDR_MODE_CTRL, 8'hcc);
        chk(ramp_divisor_o, 8'ha0);
        chk({6'h00, ramp_amp_o}, 8'h01);
        chk({7'h00, manual_o}, 8'h00);
        period(per);
        chk(per[7:0], 8'ha0);
        wr(rss_pkg::ADDR_MODE_CTRL, 8'h10);
        chk({7'h00, manual_o}, 8'h01);
        chk(ramp_divisor_o, 8'h10);
        chk({6'h00, ramp_amp_o}, 8'h02);
        rd(rss_pkg::ADDR_STATUS, rd_val);
        chk(rd_val & 8'h02, 8'h02);
        period(per);
        chk(per[7:0], 8'h10);
        wr(rss_pkg::ADDR_MODE_CTRL, 8'h30);
        period(per);
        chk(per[7:0], 8'h20);
        $display("test manual_rate done");
        wr(rss_pkg::ADDR_STEPS, 8'h21);
        wr(rss_pkg::ADDR_MODE_CTRL, 8'h11);
        obs(mx);
        chk_rng(mx, 8'h01, 8'h05);
        wr(rss_pkg::ADDR_PROFILE_SEL, 8'h00);
        wr(rss_pkg::ADDR_MODE_CTRL, 8'h12);
        obs(mx);
        chk_rng(mx, 8'h01, 8'h05);
        wr(rss_pkg::ADDR_PROFILE_SEL, 8'h70);
        obs(mx);
        chk_rng(mx, 8'h06, 8'h0c);
        $display("test spreading done");
        end_sim();
    end

endmodule

`default_nettype wire
